// *** rtl/supply_loss_monitor.sv ***
// Supply-loss monitor: trip detection, glitch filter, drop limit and backup switchover.
`default_nettype none

module supply_loss_monitor (
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        rstn,
   // Supply measurement in 10 mV units.
   input  wire logic [15:0] supply_cv,
   // Serial register bus, open-drain data.
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   // Power path control.
   output logic             backup_active,
   output logic             battery_connect,
   output logic             rtc_run,
   // Event pulses.
   output logic             trip_pulse,
   output logic             switch_pulse
);

   // ************************************************************
   // Helper functions.
   // ************************************************************

   // Converts a reading in 10 mV units to millivolts.
   function automatic logic [19:0] to_mv(input logic [15:0] cv);
      to_mv = 20'(cv) * 20'(supply_monitor_pkg::MV_PER_LSB);
   endfunction

   // Returns the trip point of a reference level in millivolts.
   function automatic logic [19:0] ref_mv(input logic [7:0] level);
      case (level)
         8'h01:   ref_mv = 20'(supply_monitor_pkg::REF1_MV);
         8'h02:   ref_mv = 20'(supply_monitor_pkg::REF2_MV);
         8'h03:   ref_mv = 20'(supply_monitor_pkg::REF3_MV);
         8'h04:   ref_mv = 20'(supply_monitor_pkg::REF4_MV);
         default: ref_mv = 20'h0_0000;
      endcase
   endfunction

   // Returns the allowed extra drop in millivolts, held to the legal range.
   function automatic logic [19:0] drop_mv(input logic [7:0] code);
      logic [7:0] c;
      c = code;
      if (c < supply_monitor_pkg::DROP_MIN) begin
         c = supply_monitor_pkg::DROP_MIN;
      end else if (c > supply_monitor_pkg::DROP_MAX) begin
         c = supply_monitor_pkg::DROP_MAX;
      end
      drop_mv = 20'(c) * 20'(supply_monitor_pkg::DROP_STEP_MV);
   endfunction

   // ************************************************************
   // State.
   // ************************************************************
   typedef enum logic [2:0] {
      MS_IDLE   = 3'b001,  // Supply above the trip point.
      MS_WATCH  = 3'b010,  // Tripped, filtering the dip.
      MS_BACKUP = 3'b100   // Running from the battery.
   } mon_state_t;

   typedef struct packed {
      mon_state_t  st;          // Monitoring phase.
      logic [6:0]  prescale;    // Cycles within one filter count.
      logic [7:0]  gap_cnt;     // Filter counts elapsed in the dip.
      logic [7:0]  filter_dur;  // Glitch filter duration setting.
      logic [7:0]  ref_sel;     // Trip reference select setting.
      logic [7:0]  extra_drop;  // Allowed extra drop setting.
      logic [15:0] trip_v;      // Supply reading at trip.
      logic [15:0] switch_v;    // Supply reading at switchover.
      logic        backup;      // Battery selected.
      logic        batt_conn;   // Battery attached to the system.
      logic        rtc_on;      // Real-time clock kept running.
      logic        trip_p;      // Trip event pulse.
      logic        switch_p;    // Switchover event pulse.
   } mon_regs_t;

   mon_regs_t   r_reg;       // Registered state.
   mon_regs_t   r_next;      // Next state.

   logic        bus_dev_cfg;  // Transfer addresses the settings.
   logic [7:0]  bus_addr;     // Register pointer of the transfer.
   logic [7:0]  bus_rd_data;  // Byte returned to the bus.
   logic        bus_wr_stb;   // Write strobe.
   logic [7:0]  bus_wr_addr;  // Write target.
   logic [7:0]  bus_wr_data;  // Write value.
   logic        bus_wr_dev;   // Settings address held for the write.

   logic [19:0] now_mv;       // Present supply in mV.
   logic [19:0] trip_mv;      // Trip point in mV.
   logic [19:0] cut_mv;       // Trip point less the allowed drop.
   logic [7:0]  dur_eff;      // Filter length in counts, capped.
   logic        enabled;      // Backup function switched on.

   // ************************************************************
   // Register port.
   // ************************************************************
   serial_reg_port u_port (
      .core_clk    (core_clk),
      .rstn        (rstn),
      .scl_in      (scl_in),
      .sda_in      (sda_in),
      .sda_out     (sda_out),
      .sda_oe      (sda_oe),
      .reg_dev_cfg (bus_dev_cfg),
      .reg_addr    (bus_addr),
      .reg_rd_data (bus_rd_data),
      .reg_wr_stb  (bus_wr_stb),
      .reg_wr_addr (bus_wr_addr),
      .reg_wr_data (bus_wr_data)
   );

   // The address selection stays stable for the whole transfer.
   assign bus_wr_dev = bus_dev_cfg;

   // Read multiplexer; unmapped offsets return zero.
   always_comb begin
      bus_rd_data = 8'h00;
      if (bus_dev_cfg) begin
         case (bus_addr)
            supply_monitor_pkg::OFS_FILTER_DUR: bus_rd_data = r_reg.filter_dur;
            supply_monitor_pkg::OFS_REF_SELECT: bus_rd_data = r_reg.ref_sel;
            supply_monitor_pkg::OFS_EXTRA_DROP: bus_rd_data = r_reg.extra_drop;
            default:                            bus_rd_data = 8'h00;
         endcase
      end else begin
         // Voltages are read as words, low byte first.
         case (bus_addr)
            supply_monitor_pkg::OFS_TRIP_LO:   bus_rd_data = r_reg.trip_v[7:0];
            supply_monitor_pkg::OFS_TRIP_HI:   bus_rd_data = r_reg.trip_v[15:8];
            supply_monitor_pkg::OFS_SWITCH_LO: bus_rd_data = r_reg.switch_v[7:0];
            supply_monitor_pkg::OFS_SWITCH_HI: bus_rd_data = r_reg.switch_v[15:8];
            default:                           bus_rd_data = 8'h00;
         endcase
      end
   end

   // ************************************************************
   // Thresholds.
   // ************************************************************

   // Trip and cut levels follow the present settings.
   always_comb begin
      now_mv  = to_mv(supply_cv);
      trip_mv = ref_mv(r_reg.ref_sel);
      enabled = (r_reg.ref_sel != supply_monitor_pkg::REF_OFF);
      if (trip_mv > drop_mv(r_reg.extra_drop)) begin
         cut_mv = trip_mv - drop_mv(r_reg.extra_drop);
      end else begin
         cut_mv = 20'h0_0000;
      end
      // Counts above the longest filter time are held at it.
      if (r_reg.filter_dur > supply_monitor_pkg::FILTER_MAX_CNT) begin
         dur_eff = supply_monitor_pkg::FILTER_MAX_CNT;
      end else begin
         dur_eff = r_reg.filter_dur;
      end
   end

   // ************************************************************
   // Settings, monitoring and switchover.
   // ************************************************************

   // Next-state logic for settings and the monitoring sequence.
   always_comb begin
      r_next          = r_reg;
      r_next.trip_p   = 1'b0;
      r_next.switch_p = 1'b0;

      // Setting writes; reference codes above the highest level are refused.
      if (bus_wr_stb && bus_wr_dev) begin
         case (bus_wr_addr)
            supply_monitor_pkg::OFS_FILTER_DUR: begin
               r_next.filter_dur = bus_wr_data;
            end
            supply_monitor_pkg::OFS_REF_SELECT: begin
               if (bus_wr_data <= supply_monitor_pkg::REF_LEVEL_MAX) begin
                  r_next.ref_sel = bus_wr_data;
               end
            end
            supply_monitor_pkg::OFS_EXTRA_DROP: begin
               r_next.extra_drop = bus_wr_data;
            end
            default: begin
            end
         endcase
      end

      case (r_reg.st)
         MS_IDLE: begin
            // Falling through the trip point starts the filter.
            if (enabled && now_mv < trip_mv) begin
               r_next.trip_v   = supply_cv;
               r_next.trip_p   = 1'b1;
               r_next.prescale = 7'h00;
               r_next.gap_cnt  = 8'h00;
               r_next.st       = MS_WATCH;
            end
         end
         MS_WATCH: begin
            if (now_mv >= trip_mv) begin
               // Dip ended short and shallow: back to normal.
               r_next.st = MS_IDLE;
            end else if (now_mv < cut_mv || r_reg.gap_cnt >= dur_eff) begin
               // Whichever comes first selects the battery.
               r_next.switch_v = supply_cv;
               r_next.switch_p = 1'b1;
               r_next.backup   = 1'b1;
               r_next.st       = MS_BACKUP;
            end else if (r_reg.prescale == supply_monitor_pkg::PRESCALE_LAST) begin
               // One filter count has passed.
               r_next.prescale = 7'h00;
               r_next.gap_cnt  = r_reg.gap_cnt + 8'h01;
            end else begin
               r_next.prescale = r_reg.prescale + 7'h01;
            end
         end
         MS_BACKUP: begin
            // Supply restored above the trip point: return to the cable.
            if (now_mv >= trip_mv) begin
               r_next.backup = 1'b0;
               r_next.st     = MS_IDLE;
            end
         end
         default: begin
            r_next.backup = 1'b0;
            r_next.st     = MS_IDLE;
         end
      endcase

      // Disabled backup overrides the sequence and releases the battery. The new setting
      // is used, so no trip or switchover slips out on the edge where the write lands.
      if (r_next.ref_sel == supply_monitor_pkg::REF_OFF) begin
         r_next.backup   = 1'b0;
         r_next.trip_p   = 1'b0;
         r_next.switch_p = 1'b0;
         r_next.st       = MS_IDLE;
      end
      r_next.batt_conn = (r_next.ref_sel != supply_monitor_pkg::REF_OFF);
      r_next.rtc_on    = (r_next.ref_sel != supply_monitor_pkg::REF_OFF);
   end

   // State register with documented setting defaults.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         r_reg            <= '0;
         r_reg.st         <= MS_IDLE;
         r_reg.filter_dur <= supply_monitor_pkg::RST_FILTER_DUR;
         r_reg.ref_sel    <= supply_monitor_pkg::RST_REF_SELECT;
         r_reg.extra_drop <= supply_monitor_pkg::RST_EXTRA_DROP;
         r_reg.batt_conn  <= 1'b1;
         r_reg.rtc_on     <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // Outputs come straight from the state register.
   assign backup_active   = r_reg.backup;
   assign battery_connect = r_reg.batt_conn;
   assign rtc_run         = r_reg.rtc_on;
   assign trip_pulse      = r_reg.trip_p;
   assign switch_pulse    = r_reg.switch_p;

endmodule

`default_nettype wire

// *** rtl/supply_monitor_pkg.sv ***
// Shared constants for the supply-loss monitor and its two-address serial register port.
`default_nettype none

package supply_monitor_pkg;

   // ************************************************************
   // Serial bus addresses and register offsets.
   // ************************************************************
   localparam logic [6:0] STATUS_BUS_ADDR = 7'h69;   // Address holding the captured voltages.
   localparam logic [6:0] CONFIG_BUS_ADDR = 7'h6b;   // Address holding the settings.
   localparam logic [7:0] OFS_TRIP_LO     = 8'h02;   // Trip voltage, low byte.
   localparam logic [7:0] OFS_TRIP_HI     = 8'h03;   // Trip voltage, high byte.
   localparam logic [7:0] OFS_SWITCH_LO   = 8'h04;   // Switchover voltage, low byte.
   localparam logic [7:0] OFS_SWITCH_HI   = 8'h05;   // Switchover voltage, high byte.
   localparam logic [7:0] OFS_FILTER_DUR  = 8'h1a;   // Glitch filter duration.
   localparam logic [7:0] OFS_REF_SELECT  = 8'h1b;   // Trip reference select.
   localparam logic [7:0] OFS_EXTRA_DROP  = 8'h1c;   // Allowed extra drop.

   // ************************************************************
   // Reset values of the settings.
   // ************************************************************
   localparam logic [7:0] RST_FILTER_DUR  = 8'h19;   // 25 counts, 250 us.
   localparam logic [7:0] RST_REF_SELECT  = 8'h02;   // Reference level 2.
   localparam logic [7:0] RST_EXTRA_DROP  = 8'h03;   // 0.3 V.

   // ************************************************************
   // Reference codes and voltage figures.
   // ************************************************************
   localparam logic [7:0] REF_OFF         = 8'h00;   // Backup disabled.
   localparam logic [7:0] REF_LEVEL_MAX   = 8'h04;   // Highest legal level code.
   localparam int         REF1_MV         = 4918;    // Level 1 trip point in mV.
   localparam int         REF2_MV         = 4645;    // Level 2 trip point in mV.
   localparam int         REF3_MV         = 4372;    // Level 3 trip point in mV.
   localparam int         REF4_MV         = 4096;    // Level 4 trip point in mV.
   localparam int         MV_PER_LSB      = 10;      // Voltage readings count 10 mV.
   localparam int         DROP_STEP_MV    = 100;     // One drop step is 0.1 V.
   localparam logic [7:0] DROP_MIN        = 8'h01;   // Least drop code, 0.1 V.
   localparam logic [7:0] DROP_MAX        = 8'h09;   // Greatest drop code, 0.9 V.

   // ************************************************************
   // Timing.
   // ************************************************************
   localparam int         CLK_HZ          = 10_000_000;  // Core clock rate.
   localparam int         FILTER_STEP_US  = 10;          // One filter count in us.
   localparam int         FILTER_MAX_US   = 2500;        // Longest filter time in us.
   localparam int         FILTER_STEP_CYC = (FILTER_STEP_US * (CLK_HZ / 1_000_000));
   localparam logic [7:0] FILTER_MAX_CNT  = 8'(FILTER_MAX_US / FILTER_STEP_US);
   localparam logic [6:0] PRESCALE_LAST   = 7'(FILTER_STEP_CYC - 1);

endpackage

`default_nettype wire

// *** rtl/serial_reg_port.sv ***
// Two-address serial register slave, open-drain data, pointer then data bytes.
`default_nettype none

module serial_reg_port (
   // Clock and reset.
   input  wire logic       core_clk,
   input  wire logic       rstn,
   // Bus pins.
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   // Register side.
   output logic            reg_dev_cfg,
   output logic [7:0]      reg_addr,
   input  wire logic [7:0] reg_rd_data,
   output logic            reg_wr_stb,
   output logic [7:0]      reg_wr_addr,
   output logic [7:0]      reg_wr_data
);

   // ************************************************************
   // State.
   // ************************************************************
   typedef enum logic [6:0] {
      PS_IDLE = 7'b000_0001,
      PS_ADDR = 7'b000_0010,
      PS_AACK = 7'b000_0100,
      PS_WR   = 7'b000_1000,
      PS_WACK = 7'b001_0000,
      PS_RD   = 7'b010_0000,
      PS_RACK = 7'b100_0000
   } port_state_t;

   typedef struct packed {
      port_state_t st;       // Transfer phase.
      logic        scl_q;    // Clock pin one cycle ago.
      logic        sda_q;    // Data pin one cycle ago.
      logic [3:0]  bitcnt;   // Bits moved in the current byte.
      logic [7:0]  shreg;    // Byte being shifted.
      logic        dev_cfg;  // Selected address is the settings one.
      logic [7:0]  ptr;      // Register pointer.
      logic        ptr_set;  // Pointer byte already received.
      logic        rnw;      // Read transfer.
      logic        sda_oe;   // Pulling data low.
      logic        sda_o;    // Driven level, always low.
      logic        wr_stb;   // One-cycle write strobe.
      logic [7:0]  wr_addr;  // Write target.
      logic [7:0]  wr_data;  // Write value.
   } port_regs_t;

   port_regs_t r_reg;
   port_regs_t r_next;

   logic scl_rise;  // Clock edge where data is sampled.
   logic scl_fall;  // Clock edge where data may change.
   logic start_c;   // Start condition seen.
   logic stop_c;    // Stop condition seen.

   // Pin edges and bus conditions from the previous sample.
   always_comb begin
      scl_rise = scl_in & ~r_reg.scl_q;
      scl_fall = ~scl_in & r_reg.scl_q;
      start_c  = scl_in & r_reg.scl_q & r_reg.sda_q & ~sda_in;
      stop_c   = scl_in & r_reg.scl_q & ~r_reg.sda_q & sda_in;
   end

   // Byte framing, acknowledge and pointer handling.
   always_comb begin
      r_next        = r_reg;
      r_next.scl_q  = scl_in;
      r_next.sda_q  = sda_in;
      r_next.wr_stb = 1'b0;
      r_next.sda_o  = 1'b0;
      if (start_c) begin
         // A start, repeated or not, always opens a new address byte.
         r_next.st     = PS_ADDR;
         r_next.bitcnt = 4'h0;
         r_next.sda_oe = 1'b0;
      end else if (stop_c) begin
         r_next.st     = PS_IDLE;
         r_next.sda_oe = 1'b0;
      end else begin
         case (r_reg.st)
            PS_IDLE: begin
               r_next.sda_oe = 1'b0;
            end
            PS_ADDR, PS_WR: begin
               if (scl_rise) begin
                  r_next.shreg  = {r_reg.shreg[6:0], sda_in};
                  r_next.bitcnt = r_reg.bitcnt + 4'h1;
               end else if (scl_fall && r_reg.bitcnt == 4'h8) begin
                  if (r_reg.st == PS_WR) begin
                     // First data byte is the pointer, later ones are written.
                     r_next.sda_oe = 1'b1;
                     r_next.st     = PS_WACK;
                     if (!r_reg.ptr_set) begin
                        r_next.ptr     = r_reg.shreg;
                        r_next.ptr_set = 1'b1;
                     end else begin
                        r_next.wr_stb  = 1'b1;
                        r_next.wr_addr = r_reg.ptr;
                        r_next.wr_data = r_reg.shreg;
                        r_next.ptr     = r_reg.ptr + 8'h01;
                     end
                  end else if (r_reg.shreg[7:1] == supply_monitor_pkg::STATUS_BUS_ADDR ||
                               r_reg.shreg[7:1] == supply_monitor_pkg::CONFIG_BUS_ADDR) begin
                     // Claim the address and pull the acknowledge low.
                     r_next.dev_cfg = (r_reg.shreg[7:1] == supply_monitor_pkg::CONFIG_BUS_ADDR);
                     r_next.rnw     = r_reg.shreg[0];
                     r_next.ptr_set = 1'b0;
                     r_next.sda_oe  = 1'b1;
                     r_next.st      = PS_AACK;
                  end else begin
                     // Foreign address: stay off the bus until the next start.
                     r_next.st = PS_IDLE;
                  end
               end
            end
            PS_AACK, PS_RACK: begin
               if (r_reg.st == PS_RACK && scl_rise && sda_in) begin
                  // Master refused further data.
                  r_next.st = PS_IDLE;
               end else if (scl_fall) begin
                  if (r_reg.rnw) begin
                     // Load the addressed byte and present its top bit.
                     r_next.shreg  = reg_rd_data;
                     r_next.sda_oe = ~reg_rd_data[7];
                     r_next.bitcnt = 4'h1;
                     r_next.ptr    = r_reg.ptr + 8'h01;
                     r_next.st     = PS_RD;
                  end else begin
                     r_next.sda_oe = 1'b0;
                     r_next.bitcnt = 4'h0;
                     r_next.st     = PS_WR;
                  end
               end
            end
            PS_WACK: begin
               if (scl_fall) begin
                  r_next.sda_oe = 1'b0;
                  r_next.bitcnt = 4'h0;
                  r_next.st     = PS_WR;
               end
            end
            PS_RD: begin
               if (scl_fall) begin
                  if (r_reg.bitcnt == 4'h8) begin
                     r_next.sda_oe = 1'b0;
                     r_next.st     = PS_RACK;
                  end else begin
                     r_next.sda_oe = ~r_reg.shreg[6];
                     r_next.shreg  = {r_reg.shreg[6:0], 1'b0};
                     r_next.bitcnt = r_reg.bitcnt + 4'h1;
                  end
               end
            end
            default: begin
               r_next.st     = PS_IDLE;
               r_next.sda_oe = 1'b0;
            end
         endcase
      end
   end

   // State register; idle bus levels are assumed high at reset.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         r_reg       <= '0;
         r_reg.st    <= PS_IDLE;
         r_reg.scl_q <= 1'b1;
         r_reg.sda_q <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign sda_out     = r_reg.sda_o;
   assign sda_oe      = r_reg.sda_oe;
   assign reg_dev_cfg = r_reg.dev_cfg;
   assign reg_addr    = r_reg.ptr;
   assign reg_wr_stb  = r_reg.wr_stb;
   assign reg_wr_addr = r_reg.wr_addr;
   assign reg_wr_data = r_reg.wr_data;

endmodule

`default_nettype wire

// *** tb/supply_loss_monitor_chk.sv ***
// Port checker for the supply-loss monitor.
`default_nettype none
module supply_loss_monitor_chk (
   input wire logic        core_clk, rstn, sda_out, sda_oe,
   input wire logic [15:0] supply_cv,
   input wire logic        backup_active, battery_connect, rtc_run, trip_pulse, switch_pulse
);
   timeunit 1ns; timeprecision 1ns;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // A trip is a lone one-cycle pulse.
   sequence s_lone_trip; trip_pulse ##1 !trip_pulse; endsequence
   a_trip_lone: assert property (trip_pulse |-> s_lone_trip) else $error("trip too long");
   a_trip_alone: assert property (trip_pulse |-> !switch_pulse) else $error("trip switched");
   a_trip_level: assert property (trip_pulse |-> $past(supply_cv) < 16'h01ec)
      else $error("trip above level");
   a_switch_low: assert property (switch_pulse |-> $past(supply_cv) < 16'h01ec)
      else $error("switch above level");
   a_backup_cause: assert property ($rose(backup_active) |-> switch_pulse)
      else $error("backup without switch");
   a_switch_once: assert property (switch_pulse |-> backup_active ##1 !switch_pulse)
      else $error("switch pulse bad");
   a_off_mirror: assert property (battery_connect == rtc_run) else $error("rtc mismatch");
   a_off_quiet: assert property (!battery_connect |-> !trip_pulse && !backup_active)
      else $error("activity while off");
   a_ack_low: assert property (sda_oe |-> !sda_out) else $error("data driven high");
endmodule
`default_nettype wire

// *** tb/host_model.sv ***
// Host model: serial bus master on the open-drain data line.
`default_nettype none
module host_model (
   input wire logic core_clk, sda_out, sda_oe,
   output logic     scl_in, sda_in
);
   timeunit 1ns; timeprecision 1ns;
   logic scl = 1'b1;   // Master clock line.
   logic sda = 1'b1;   // Master data drive, 1 means released.
   // Wired-AND with the pull-up: low when either party pulls.
   assign scl_in = scl;
   assign sda_in = sda & (sda_oe ? sda_out : 1'b1);
   task automatic hold(); repeat (3) @(posedge core_clk); endtask
   // Start or repeated start; data falls while the clock is high.
   task automatic start();
      sda <= 1'b1; hold(); scl <= 1'b1; hold(); sda <= 1'b0; hold(); scl <= 1'b0; hold();
   endtask
   task automatic stop(); sda <= 1'b0; hold(); scl <= 1'b1; hold(); sda <= 1'b1; hold(); endtask
   // Eight data bits then the acknowledge bit, sampled while the clock is high.
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         sda <= tx[i]; hold(); scl <= 1'b1; hold(); rx[i] = sda_in; scl <= 1'b0; hold();
      end
   endtask
   // Setting write: address, pointer, one data byte.
   task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
      logic [8:0] r;
      start(); xfer({supply_monitor_pkg::CONFIG_BUS_ADDR, 2'b01}, r);
      xfer({ofs, 1'b1}, r); xfer({d, 1'b1}, r); stop();
   endtask
   // Word read: pointer, repeated start, low byte acked, high byte refused.
   task automatic rd(input logic [6:0] a, input logic [7:0] ofs, output logic [15:0] v);
      logic [8:0] r, lo, hi;
      start(); xfer({a, 2'b01}, r); xfer({ofs, 1'b1}, r);
      start(); xfer({a, 2'b11}, r); xfer(9'h1fe, lo); xfer(9'h1ff, hi); stop();
      v = {hi[8:1], lo[8:1]};
   endtask
endmodule
`default_nettype wire

// *** tb/tb_supply_loss_monitor.sv ***
// Self-checking bench for the supply-loss monitor.
`default_nettype none
module tb_supply_loss_monitor;
   timeunit 1ns; timeprecision 1ns;
   localparam logic [6:0] cfg_a = supply_monitor_pkg::CONFIG_BUS_ADDR;
   localparam logic [6:0] sts_a = supply_monitor_pkg::STATUS_BUS_ADDR;
   logic core_clk = 1'b0, rstn = 1'b0;
   logic [15:0] supply_cv = 16'h01f4, v;
   logic scl_in, sda_in, sda_out, sda_oe, backup_active, battery_connect, rtc_run;
   logic trip_pulse, switch_pulse;
   int bad_count = 0, checked = 0, trips = 0, sws = 0, c;
   always #50 core_clk = ~core_clk;
   // Event counters seen by every scenario.
   always @(posedge core_clk) begin trips <= trips + trip_pulse; sws <= sws + switch_pulse; end
   supply_loss_monitor uut (.core_clk(core_clk), .rstn(rstn), .supply_cv(supply_cv),
      .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
      .backup_active(backup_active), .battery_connect(battery_connect), .rtc_run(rtc_run),
      .trip_pulse(trip_pulse), .switch_pulse(switch_pulse));
   host_model h (.core_clk(core_clk), .sda_out(sda_out), .sda_oe(sda_oe), .scl_in(scl_in),
      .sda_in(sda_in));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin bad_count++; $display("[FAIL] %0t got %h want %h", $time, got, exp); end
   endtask
   task automatic conclude();
      if (bad_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic run(input int n); repeat (n) @(posedge core_clk); endtask
   // Bounded wait for the next switchover, giving the cycles taken.
   task automatic wait_sw(input int n);
      int k;
      k = sws + 1;
      for (c = 0; sws < k; c++) begin
         if (c == n) begin chk(16'h0001, 16'h0000); conclude(); end
         @(posedge core_clk);
      end
   endtask
   // Short shallow dip, then resume; trip voltage read back.
   task automatic t_glitch();
      supply_cv <= 16'h01b8; run(50); supply_cv <= 16'h01f4; run(3000);
      chk(16'(trips), 16'h0001); chk(16'(sws), 16'h0000);
      h.rd(sts_a, 8'h02, v); chk(v, 16'h01b8);
   endtask
   // Drop beyond a 0.1 V limit switches at once.
   task automatic t_deep();
      h.wr(8'h1c, 8'h01); supply_cv <= 16'h01c2; wait_sw(10);
      chk(16'(backup_active), 16'h0001);
      supply_cv <= 16'h01f4; run(3); chk(16'(backup_active), 16'h0000);
      h.rd(sts_a, 8'h04, v); chk(v, 16'h01c2);
   endtask
   // Each level trips one count below its point and not one above.
   task automatic t_levels();
      int lim [4] = '{491, 464, 437, 409};
      int t0;
      for (int k = 0; k < 4; k++) begin
         h.wr(8'h1b, 8'(k + 1)); t0 = trips;
         supply_cv <= 16'(lim[k] + 1); run(10); chk(16'(trips - t0), 16'h0000);
         supply_cv <= 16'(lim[k]); run(3); supply_cv <= 16'h01f4; run(3);
         chk(16'(trips - t0), 16'h0001);
      end
      h.wr(8'h1b, 8'h05); h.rd(cfg_a, 8'h1a, v); chk(v, 16'h0419);
   endtask
   // Level zero disconnects; level two restores.
   task automatic t_off();
      int t0;
      h.wr(8'h1b, 8'h00); run(2); t0 = trips;
      chk(16'({rtc_run, battery_connect}), 16'h0000);
      supply_cv <= 16'h012c; run(20); chk(16'(trips - t0), 16'h0000);
      supply_cv <= 16'h01f4; h.wr(8'h1b, 8'h02); run(2);
      chk(16'({rtc_run, battery_connect}), 16'h0003);
   endtask
   // Longest filter: shallow loss switches after 2500 us.
   task automatic t_expiry();
      h.wr(8'h1a, 8'hff); supply_cv <= 16'h01cc; run(1); wait_sw(26000);
      chk(16'(c > 24990 && c < 25010), 16'h0001);
      supply_cv <= 16'h01f4; run(3);
   endtask
   initial begin
      run(5); rstn <= 1'b1; run(2);
      h.rd(cfg_a, 8'h1a, v); chk(v, 16'h0219);
      h.rd(cfg_a, 8'h1c, v); chk(v, 16'h0003);
      t_glitch(); t_deep(); t_levels(); t_off(); t_expiry();
      conclude();
   end
endmodule
bind supply_loss_monitor supply_loss_monitor_chk chk (.core_clk(core_clk), .rstn(rstn),
   .sda_out(sda_out), .sda_oe(sda_oe), .supply_cv(supply_cv), .backup_active(backup_active),
   .battery_connect(battery_connect), .rtc_run(rtc_run), .trip_pulse(trip_pulse),
   .switch_pulse(switch_pulse));
`default_nettype wire
